// *** rtl/burst_counter.sv ***
// Purpose: two-bit burst address counter with linear or interleaved order
// Assumes: load and advance are never high together
// Notes: eff_low is the low address used by the access taken this edge
`timescale 1ns/1ps
module burst_counter
    import sram_ctl_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic load, // new address taken
    input wire logic advance, // step the burst
    input wire logic interleave, // high selects interleaved order
    input wire logic [BURST_W-1:0] start_bits, // incoming low address
    output logic [BURST_W-1:0] eff_low, // low address of this access
    output logic [BURST_W-1:0] cur_low // low address held now
);
    logic [BURST_W-1:0] start_r;
    logic [BURST_W-1:0] step_r;
    logic [BURST_W-1:0] step_nxt;

    // order from start and step; the 2-bit step wraps to start on the fifth
    assign step_nxt = step_r + 2'h1;
    assign cur_low = interleave ? (start_r ^ step_r) : (start_r + step_r);
    always_comb begin
        if (load) begin
            eff_low = start_bits;
        end else if (advance) begin
            eff_low = interleave ? (start_r ^ step_nxt) : (start_r + step_nxt);
        end else begin
            eff_low = cur_low;
        end
    end

    // counter state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 2'h0;
            step_r <= 2'h0;
        end else if (load) begin
            start_r <= start_bits;
            step_r <= 2'h0;
        end else if (advance) begin
            step_r <= step_nxt;
        end
    end

    a_wrap_fifth: assert property (@(posedge pclk) disable iff (!presetn)
        load ##1 (advance && !load) [*4] |=> (cur_low == $past(start_r, 4)))
        else $error("burst counter did not return to its start");
    // checks the counter state, so a strap change between bursts is not a false hit
    a_suspend_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!load && !advance) |=> (step_r == $past(step_r)) && (start_r == $past(start_r)))
        else $error("burst counter moved without advance");
endmodule

// *** rtl/sram_ctl.sv ***
// Purpose: synchronous burst sram with flow/pipe output and deselect modes
// Assumes: all pins synchronous to pclk; straps already resolved to levels
// Notes: storage in flops; apb gives a sleep control and a status view
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module sram_ctl
    import sram_ctl_pkg::*;
#(
    parameter int ADDR_W = DEF_ADDR_W,
    parameter int LANES = DEF_LANES
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic [ADDR_W-1:0] addr, // word address
    input wire logic proc_addr_strobe_n, // processor strobe
    input wire logic ctrl_addr_strobe_n, // controller strobe
    input wire logic burst_advance_n, // burst advance
    input wire logic chip_select_n, // chip select
    input wire logic all_lane_write_n, // global write
    input wire logic lane_write_gate_n, // lane write gate
    input wire logic lane_a_write_n, // lane a enable
    input wire logic lane_b_write_n, // lane b enable
    input wire logic lane_c_write_n, // lane c enable, 36-bit only
    input wire logic lane_d_write_n, // lane d enable, 36-bit only
    input wire logic out_enable_n, // output enable
    input wire logic sleep_request, // sleep, high
    input wire logic flowthrough_select_n, // low flow-through
    input wire logic linear_order_select_n, // low linear order
    input wire logic deselect_depth_select, // high single deselect
    input wire logic drive_strength_select, // drive strength, status only
    input wire logic [LANES*LANE_W-1:0] data_in, // data pins in
    output logic [LANES*LANE_W-1:0] data_out, // data pins out
    output logic [LANES*LANE_W-1:0] data_oe, // data pin enables
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [APB_AW-1:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr // apb error
);
    localparam int DW = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int UP_W = ADDR_W - BURST_W;

    logic [LANES-1:0] lane_n_all;
    logic [LANES-1:0] lane_we;
    logic is_write;
    logic sleep_now;
    logic sel_start;
    logic proc_start;
    logic desel;
    logic cont;
    logic access;
    logic wr_now;
    logic rd_now;
    logic advance;
    logic pipelined;
    logic single_desel;
    logic drive_nxt;
    logic [BURST_W-1:0] eff_low;
    logic [BURST_W-1:0] cur_low;
    logic [ADDR_W-1:0] idx;
    logic [DW-1:0] rd_word;
    logic [UP_W-1:0] upper_r;
    logic active_r;
    logic pipe_rd_r;
    logic [DW-1:0] pipe_data_r;
    logic drive_r;
    logic [DW-1:0] data_out_r;
    logic [DW-1:0] data_oe_r;
    logic ctrl_sleep_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] status_w;

    // lanes c and d are cut away in the 18-bit organisation
    assign lane_n_all = LANES > 2 ?
        LANES'({lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n}) :
        LANES'({lane_b_write_n, lane_a_write_n});

    write_decode #(.LANES(LANES)) u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .all_lane_write_n(all_lane_write_n),
        .lane_write_gate_n(lane_write_gate_n),
        .lane_write_n(lane_n_all),
        .lane_we(lane_we),
        .is_write(is_write)
    );

    // strap meaning; pull defaults arrive as high on flow and deselect, low on sleep
    assign pipelined = flowthrough_select_n;
    assign single_desel = deselect_depth_select;
    assign sleep_now = sleep_request || ctrl_sleep_r;

    // cycle classification from the pins sampled at this edge
    assign sel_start = !sleep_now && !chip_select_n
        && (!proc_addr_strobe_n || !ctrl_addr_strobe_n);
    assign proc_start = sel_start && !proc_addr_strobe_n; // processor start is a read
    assign desel = !sleep_now && chip_select_n && !ctrl_addr_strobe_n;
    assign cont = !sleep_now && active_r && !sel_start && !desel;
    assign access = sel_start || cont;
    assign wr_now = access && !proc_start && is_write;
    assign rd_now = access && !wr_now; // dummy reads count here too
    assign advance = cont && !burst_advance_n;

    burst_counter u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .load(sel_start),
        .advance(advance),
        .interleave(linear_order_select_n),
        .start_bits(addr[BURST_W-1:0]),
        .eff_low(eff_low),
        .cur_low(cur_low)
    );

    assign idx = {(sel_start ? addr[ADDR_W-1:BURST_W] : upper_r), eff_low};

    // upper address and burst activity, sampled on the rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_r <= '0;
            active_r <= 1'b0;
        end else if (sel_start) begin
            upper_r <= addr[ADDR_W-1:BURST_W];
            active_r <= 1'b1;
        end else if (desel || sleep_now) begin
            active_r <= 1'b0;
        end
    end

    // storage, one array per lane; no reset so contents survive sleep
    for (genvar l = 0; l < LANES; l++) begin : g_mem
        logic [LANE_W-1:0] mem [DEPTH];
        always_ff @(posedge pclk) begin
            if (wr_now && lane_we[l]) begin
                mem[idx] <= data_in[l*LANE_W +: LANE_W];
            end
        end
        assign rd_word[l*LANE_W +: LANE_W] = mem[idx];
    end

    // pipeline stage behind the array; data used only in pipelined mode, read flag also for flow dual deselect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe_rd_r <= 1'b0;
            pipe_data_r <= '0;
        end else begin
            pipe_rd_r <= rd_now;
            if (rd_now) begin
                pipe_data_r <= rd_word;
            end
        end
    end

    // drive decision: single deselect drops at the deselect edge, dual one stage later
    // flow hold keys on last cycle's read, so a run of deselects cannot keep pins on
    always_comb begin
        if (sleep_now || wr_now) begin
            drive_nxt = 1'b0;
        end else if (pipelined) begin
            drive_nxt = pipe_rd_r && !(single_desel && desel);
        end else begin
            drive_nxt = rd_now || (!single_desel && desel && pipe_rd_r);
        end
    end

    // output data and enables, all lanes together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_r <= 1'b0;
            data_out_r <= '0;
            data_oe_r <= '0;
        end else begin
            drive_r <= drive_nxt;
            data_oe_r <= {DW{drive_nxt && !out_enable_n}};
            if (pipelined && pipe_rd_r) begin
                data_out_r <= pipe_data_r;
            end else if (!pipelined && rd_now) begin
                data_out_r <= rd_word;
            end
        end
    end
    assign data_out = data_out_r;
    assign data_oe = data_oe_r;

    // status view of the block's own state and the strap levels
    always_comb begin
        status_w = 32'h0;
        status_w[ST_LOW_POS +: BURST_W] = cur_low;
        status_w[ST_ACTIVE_POS] = active_r;
        status_w[ST_DRIVE_POS] = drive_r;
        status_w[ST_SLEEP_POS] = sleep_now;
        status_w[ST_FLOW_POS] = !flowthrough_select_n;
        status_w[ST_LINEAR_POS] = !linear_order_select_n;
        status_w[ST_SINGLE_POS] = deselect_depth_select;
        status_w[ST_STRENGTH_POS] = drive_strength_select;
    end

    // apb slave: zero wait, read data and error prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_sleep_r <= CTRL_SLEEP_RST;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            if (psel && !penable) begin
                pslverr_r <= !(paddr == CTRL_OFS || paddr == STATUS_OFS);
                if (paddr == CTRL_OFS) begin
                    prdata_r <= {31'h0, ctrl_sleep_r};
                end else if (paddr == STATUS_OFS) begin
                    prdata_r <= status_w;
                end else begin
                    prdata_r <= 32'h0;
                end
            end
            if (psel && penable && pwrite && paddr == CTRL_OFS) begin
                ctrl_sleep_r <= pwdata[CTRL_SLEEP_BIT];
            end
        end
    end
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    a_write_hiz: assert property (@(posedge pclk) disable iff (!presetn)
        wr_now |=> (data_oe == '0))
        else $error("data driven during a write");
    a_oe_gate: assert property (@(posedge pclk) disable iff (!presetn)
        out_enable_n |=> (data_oe == '0))
        else $error("data driven with output enable high");
    a_sleep_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_now |=> (data_oe == '0) && !active_r)
        else $error("activity during sleep");
    a_flow_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (!pipelined && rd_now && !out_enable_n) |=> (&data_oe) && (data_out == $past(rd_word)))
        else $error("flow-through read data wrong");
    a_pipe_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (pipelined && rd_now) ##1 (pipelined && !desel && !wr_now && !sleep_now)
        |=> (data_out == $past(rd_word, 2)))
        else $error("pipelined read data wrong");
    a_single_off: assert property (@(posedge pclk) disable iff (!presetn)
        (single_desel && pipelined && desel) |=> !drive_r ##1 !drive_r)
        else $error("single deselect did not turn off");
    a_dcd_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!single_desel && pipelined && pipe_rd_r && desel && !sleep_now) |=> drive_r)
        else $error("dual deselect turned off early");
    a_dummy_step: assert property (@(posedge pclk) disable iff (!presetn)
        (cont && !burst_advance_n && out_enable_n) |=> (cur_low != $past(cur_low)))
        else $error("dummy read did not advance");
    a_load_start: assert property (@(posedge pclk) disable iff (!presetn)
        sel_start |=> (cur_low == $past(addr[BURST_W-1:0])))
        else $error("new address did not preset the counter");
endmodule

// *** rtl/sram_ctl_pkg.sv ***
// Purpose: shared constants for the synchronous burst sram control block
// Assumes: one clock pclk at 100 MHz, apb register access
// Notes: the overview below lists the behaviour the block keeps
// Overview of operation
// - all synchronous pins are sampled on the rising clock edge
// - two low address bits preset the burst counter when an address is taken
// - linear order adds one modulo four, interleaved order xors a step count
// - after four addresses the counter returns to its start on the fifth clock
// - counter advances only with advance asserted and no new address strobe
// - read data is driven only while output enable is low
// - flow-through strap low bypasses the output register, else pipelined
// - sleep high enters standby and keeps contents; low is normal operation
// - deselect strap low gives dual cycle deselect, high gives single cycle
// - unconnected straps default to pipelined, single deselect, normal drive, awake
// - global write low writes every lane regardless of lane controls
// - lane gate low writes only lanes whose enables are low
// - a cycle is a read when no write lane is selected
// - each lane enable covers its own eight data bits and parity bit
// - reads drive every lane whatever the lane enables
// - data pins stay undriven in every write cycle
// - lanes c and d exist only in the 36-bit organisation
// - single deselect turns off at once, dual deselect one cycle later
// - dummy reads with output enable high advance the counter like reads
package sram_ctl_pkg;
    localparam int LANE_W = 9;           // eight data bits and one parity bit
    localparam int BURST_W = 2;
    localparam int DEF_ADDR_W = 19;
    localparam int DEF_LANES = 4;
    localparam int APB_AW = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam int CTRL_SLEEP_BIT = 0;
    localparam logic CTRL_SLEEP_RST = 1'b0;
    localparam int ST_LOW_POS = 0;       // two bits of burst address
    localparam int ST_ACTIVE_POS = 2;
    localparam int ST_DRIVE_POS = 3;
    localparam int ST_SLEEP_POS = 4;
    localparam int ST_FLOW_POS = 5;
    localparam int ST_LINEAR_POS = 6;
    localparam int ST_SINGLE_POS = 7;
    localparam int ST_STRENGTH_POS = 8;
endpackage

// *** rtl/write_decode.sv ***
// Purpose: per-lane and global write decoding
// Assumes: lane enables already trimmed to the lanes fitted
// Notes: purely combinational
`timescale 1ns/1ps
module write_decode
    import sram_ctl_pkg::*;
#(
    parameter int LANES = DEF_LANES
) (
    input wire logic pclk, // clock, assertions only
    input wire logic presetn, // reset, assertions only
    input wire logic all_lane_write_n, // global write, low
    input wire logic lane_write_gate_n, // lane write gate, low
    input wire logic [LANES-1:0] lane_write_n, // per-lane enables, low
    output logic [LANES-1:0] lane_we, // lanes written
    output logic is_write // any lane written
);
    // one decode per lane
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign lane_we[i] = !all_lane_write_n
            || (!lane_write_gate_n && !lane_write_n[i]);
    end
    assign is_write = |lane_we;

    a_global_all: assert property (@(posedge pclk) disable iff (!presetn)
        !all_lane_write_n |-> (&lane_we))
        else $error("global write left a lane out");
    a_lane_exact: assert property (@(posedge pclk) disable iff (!presetn)
        (all_lane_write_n && !lane_write_gate_n) |-> (lane_we == ~lane_write_n))
        else $error("lane write mismatch");
    a_read_case: assert property (@(posedge pclk) disable iff (!presetn)
        (all_lane_write_n && (lane_write_gate_n || (&lane_write_n))) |-> !is_write)
        else $error("read cycle decoded as write");
endmodule

// *** tb/mem_host.sv ***
// Purpose: host model that drives the memory bus pins of the sram block
// Assumes: cyc is entered right after a rising edge of pclk
// Notes: data lines toggle while released, so stale data never looks valid
`timescale 1ns/1ps
module mem_host (
    input wire logic pclk, // clock
    output logic [5:0] addr, // word address
    output logic proc_addr_strobe_n, // processor strobe
    output logic ctrl_addr_strobe_n, // controller strobe
    output logic burst_advance_n, // advance
    output logic chip_select_n, // select
    output logic all_lane_write_n, // global write
    output logic lane_write_gate_n, // lane gate
    output logic [3:0] lane_write_n, // lane enables d..a
    output logic [35:0] data_in // write data
);
    // idle pins at time zero
    initial begin
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
        {chip_select_n, all_lane_write_n, lane_write_gate_n} = 3'h7;
        lane_write_n = 4'hf;
        addr = 6'h00;
        data_in = 36'h0;
    end

    // kinds: 0 read, 1 write all, 2 lane write, 3 proc read,
    // 4 advance, 5 suspend, 6 deselect; held until the taking edge
    task automatic cyc(input logic [2:0] k, input logic [5:0] a, input logic [35:0] d,
            input logic [3:0] be);
        addr <= a;
        chip_select_n <= (k > 3'd3);
        ctrl_addr_strobe_n <= !(k < 3'd3 || k == 3'd6);
        proc_addr_strobe_n <= (k != 3'd3);
        burst_advance_n <= (k != 3'd4);
        all_lane_write_n <= !(k == 3'd1 || k == 3'd3);
        lane_write_gate_n <= (k != 3'd2);
        lane_write_n <= (k == 3'd2) ? be : 4'hf;
        data_in <= (k == 3'd1 || k == 3'd2) ? d : ~data_in;
        @(posedge pclk);
    endtask
endmodule

// *** tb/tb_sram_ctl.sv ***
// Purpose: self-checking bench for the burst sram block
// Assumes: pins change by nba at rising edges, results logged at edges
// Notes: hd/ho index k holds the outputs as seen just before edge k
`timescale 1ns/1ps
module tb_sram_ctl
    import sram_ctl_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic out_enable_n = 1'b0;
    logic sleep_request = 1'b0;
    logic flowthrough_select_n = 1'b1;
    logic linear_order_select_n = 1'b0;
    logic deselect_depth_select = 1'b1;
    logic drive_strength_select = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, proc_n, ctrl_n, step_n, cs_n, all_wr_n, gate_n;
    logic [5:0] addr;
    logic [3:0] lane_n;
    logic [35:0] data_in, data_out, data_oe;
    logic [35:0] hd [0:1023];
    logic [35:0] ho [0:1023];
    logic [35:0] mem [0:63];
    int ne = 0;
    int n_fail = 0;
    int n_compared = 0;

    sram_ctl #(.ADDR_W(6), .LANES(4)) sram_ctl_i (.pclk(pclk), .presetn(presetn),
        .addr(addr), .proc_addr_strobe_n(proc_n), .ctrl_addr_strobe_n(ctrl_n),
        .burst_advance_n(step_n), .chip_select_n(cs_n), .all_lane_write_n(all_wr_n),
        .lane_write_gate_n(gate_n), .lane_a_write_n(lane_n[0]), .lane_b_write_n(lane_n[1]),
        .lane_c_write_n(lane_n[2]), .lane_d_write_n(lane_n[3]), .out_enable_n(out_enable_n),
        .sleep_request(sleep_request), .flowthrough_select_n(flowthrough_select_n),
        .linear_order_select_n(linear_order_select_n),
        .deselect_depth_select(deselect_depth_select),
        .drive_strength_select(drive_strength_select), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    mem_host mem_host_i (.pclk(pclk), .addr(addr), .proc_addr_strobe_n(proc_n),
        .ctrl_addr_strobe_n(ctrl_n), .burst_advance_n(step_n), .chip_select_n(cs_n),
        .all_lane_write_n(all_wr_n), .lane_write_gate_n(gate_n), .lane_write_n(lane_n),
        .data_in(data_in));

    always #5 pclk = ~pclk;

    // output log, pre-update values at each edge
    always @(posedge pclk) begin
        hd[ne] <= data_out;
        ho[ne] <= data_oe;
        ne <= ne + 1;
    end

    task automatic end_sim();
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        $display("[ERR] %0t %s", $time, m);
        n_fail++;
    endtask

    task automatic cmp(input logic [35:0] got, input logic [35:0] want, input string m);
        n_compared++;
        if (got !== want) fail(m);
    endtask

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            if (i == 19) fail("apb wait ran out");
            if (i == 19) end_sim();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so the next call never re-raises psel in this time step
        @(posedge pclk);
    endtask

    // bus cycle plus expected memory update; e is the taking edge
    task automatic op(input logic [2:0] k, input logic [5:0] a, input logic [35:0] d,
            input logic [3:0] be, output int e);
        mem_host_i.cyc(k, a, d, be);
        e = ne;
        if (k == 3'd1) mem[a] = d;
        for (int l = 0; l < 4; l++) begin
            if (k == 3'd2 && !be[l]) mem[a][9*l +: 9] = d[9*l +: 9];
        end
    endtask

    function automatic logic [35:0] pat(input logic [5:0] a);
        return {3'd3, a, 3'd2, a, 3'd1, a, 3'd0, a};
    endfunction

    // burst of six cycles, address order worked out here, checked lat edges on
    task automatic burst(input logic [2:0] sq [6], input logic [5:0] base,
            input logic [1:0] s, input int lat, input logic il, input int dm);
        int e [6];
        logic [1:0] lo [6];
        logic [1:0] st;
        int x;
        st = 2'd0;
        for (int i = 0; i < 6; i++) begin
            if (sq[i] == 3'd4) st = st + 2'd1;
            if (sq[i] < 3'd4) st = 2'd0;
            lo[i] = il ? (s ^ st) : (s + st);
            out_enable_n <= (i == dm);
            op(sq[i], {base[5:2], s}, 36'h0, 4'hf, e[i]);
        end
        out_enable_n <= 1'b0;
        op(3'd5, 6'h0, 36'h0, 4'hf, x);
        op(3'd5, 6'h0, 36'h0, 4'hf, x);
        op(3'd6, 6'h0, 36'h0, 4'hf, x);
        for (int i = 0; i < 6; i++) begin
            if (i == dm) cmp(ho[e[i] + lat], 36'h0, "dummy read drove");
            if (i != dm) cmp(hd[e[i] + lat], mem[{base[5:2], lo[i]}], "burst data");
            if (i != dm) cmp(ho[e[i] + lat], {36{1'b1}}, "read lanes off");
        end
    endtask

    // hang guard
    initial begin
        repeat (3000) @(posedge pclk);
        fail("run did not finish");
        end_sim();
    end

    initial begin
        logic [31:0] r;
        logic e;
        int x;
        int w;
        logic [2:0] lin_seq [6] = '{3'd0, 3'd4, 3'd4, 3'd4, 3'd4, 3'd5};
        logic [2:0] il_seq [6] = '{3'd3, 3'd4, 3'd5, 3'd4, 3'd4, 3'd4};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // register view and software sleep
        apb(1'b0, CTRL_OFS, 32'h0, r, e);
        cmp({4'h0, r}, 36'h0, "ctrl reset value");
        apb(1'b0, STATUS_OFS, 32'h0, r, e);
        cmp({31'h0, r[8:4]}, 36'h1c, "strap status");
        apb(1'b0, 8'h08, 32'h0, r, e);
        cmp({3'h0, e, r}, 36'h100000000, "unmapped access");
        apb(1'b1, CTRL_OFS, 32'h1, r, e);
        apb(1'b0, STATUS_OFS, 32'h0, r, e);
        cmp({35'h0, r[4]}, 36'h1, "software sleep");
        apb(1'b1, CTRL_OFS, 32'h0, r, e);
        // read then back-to-back writes, lane writes, refused writes
        op(3'd0, 6'h10, 36'h0, 4'hf, x);
        for (int a = 16; a < 20; a++) begin
            op(3'd1, 6'(a), pat(6'(a)), 4'hf, x);
            if (a == 16) w = x;
        end
        op(3'd2, 6'h11, 36'h5_5555_5555, 4'b1101, x);
        op(3'd2, 6'h12, 36'h5_5555_5555, 4'hf, x);
        op(3'd3, 6'h13, 36'h0, 4'hf, x);
        sleep_request <= 1'b1;
        mem_host_i.cyc(3'd1, 6'h10, 36'h0, 4'hf);
        sleep_request <= 1'b0;
        op(3'd6, 6'h0, 36'h0, 4'hf, x);
        cmp(ho[w + 1], 36'h0, "write edge drove");
        burst(lin_seq, 6'h10, 2'd2, 2, 1'b0, -1);
        flowthrough_select_n <= 1'b0;
        linear_order_select_n <= 1'b1;
        op(3'd6, 6'h0, 36'h0, 4'hf, x);
        burst(il_seq, 6'h10, 2'd1, 1, 1'b1, 3);
        linear_order_select_n <= 1'b0;
        // single then dual deselect after a read, pipelined then flow-through
        for (int m = 0; m < 4; m++) begin
            deselect_depth_select <= (m % 2 == 0);
            flowthrough_select_n <= (m < 2);
            op(3'd6, 6'h0, 36'h0, 4'hf, x);
            op(3'd0, 6'h10, 36'h0, 4'hf, x);
            op(3'd6, 6'h0, 36'h0, 4'hf, w);
            op(3'd6, 6'h0, 36'h0, 4'hf, x);
            op(3'd6, 6'h0, 36'h0, 4'hf, x);
            op(3'd6, 6'h0, 36'h0, 4'hf, x);
            cmp(ho[w + 1], (m % 2 == 0) ? 36'h0 : {36{1'b1}}, "deselect first edge");
            cmp(ho[w + 2], 36'h0, "deselect second edge");
        end
        end_sim();
    end
endmodule
